// ---- design/ftpg_pkg.sv ----
// Package: register map, field layout, reset values and carriers for the field trigger pulse generator
package ftpg_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_SYNC_DIR = 8'h12;
   localparam logic [7:0] IDX_SHUT_CTRL = 8'h72;
   localparam logic [7:0] IDX_FIRST_TOGGLE = 8'h74;
   localparam logic [7:0] IDX_SECOND_TOGGLE = 8'h76;
   localparam logic [7:0] IDX_TRIG_CTRL = 8'hF1;
   localparam logic [7:0] IDX_STATUS = 8'hF2;
   // Field positions
   localparam int SYNC_DIR_BIT = 0;
   localparam int START_LEVEL_BIT = 1;
   localparam int LINE_LSB = 0;
   localparam int LINE_W = 12;
   localparam int PIXEL_LSB = 13;
   localparam int PIXEL_W = 13;
   localparam int FIELD_SEL_LSB = 0;
   localparam int FIELD_W = 3;
   localparam int TRIG_EN_BIT = 3;
   // Reset values
   localparam logic RST_SYNC_DIR = 1'b0;
   localparam logic [1:0] RST_SHUT_CTRL = 2'h0;
   localparam logic [25:0] RST_TOGGLE = 26'h0000000;
   localparam logic [3:0] RST_TRIG_CTRL = 4'h0;
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Position in the field raster from the timing core
   typedef struct packed {
      logic [FIELD_W-1:0] field;
      logic [LINE_W-1:0] line;
      logic [PIXEL_W-1:0] pixel;
   } ftpg_timing_t;

   // Toggle position as held in its register
   typedef struct packed {
      logic [PIXEL_W-1:0] pixel;
      logic spare;
      logic [LINE_W-1:0] line;
   } ftpg_toggle_t;
endpackage : ftpg_pkg

// ---- design/ftpg_field_trigger.sv ----
// Field trigger pulse generator with AXI4-Lite register slave and sync pin control
`timescale 1ns/1ns

module ftpg_field_trigger (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [9:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [9:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire ftpg_pkg::ftpg_timing_t timing,
   input wire logic sync_in,
   output logic sync_out,
   output logic sync_oe_n,
   output logic ext_sync
);

   ////////////////////////////////////////////////////////////////////////////
   // Helper functions

   // Byte-lane merge of a write into a stored word
   function automatic logic [31:0] ftpg_merge(input logic [31:0] old, input logic [31:0] data,
                                              input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return res;
   endfunction : ftpg_merge

   // Register index known to the map
   function automatic logic ftpg_mapped(input logic [7:0] idx);
      return idx == ftpg_pkg::IDX_SYNC_DIR || idx == ftpg_pkg::IDX_SHUT_CTRL ||
             idx == ftpg_pkg::IDX_FIRST_TOGGLE || idx == ftpg_pkg::IDX_SECOND_TOGGLE ||
             idx == ftpg_pkg::IDX_TRIG_CTRL || idx == ftpg_pkg::IDX_STATUS;
   endfunction : ftpg_mapped

   // Toggle position reached at the current raster point
   function automatic logic ftpg_at(input ftpg_pkg::ftpg_toggle_t pos, input ftpg_pkg::ftpg_timing_t t);
      return pos.line == t.line && pos.pixel == t.pixel;
   endfunction : ftpg_at

   ////////////////////////////////////////////////////////////////////////////
   // Registers and state

   logic sync_dir;
   logic [1:0] shut_ctrl;
   logic [25:0] first_toggle;
   logic [25:0] second_toggle;
   logic [3:0] trig_ctrl;
   logic pulse_active;
   logic [9:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode

   // Channel handshakes and the point at which a write lands
   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take = s_axi_wvalid && s_axi_wready;
   wire ar_take = s_axi_arvalid && s_axi_arready;
   wire b_take = s_axi_bvalid && s_axi_bready;
   wire r_take = s_axi_rvalid && s_axi_rready;
   wire commit = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

   // Register index from the word address
   wire [7:0] wr_idx = aw_addr[9:2];
   wire [7:0] rd_idx = s_axi_araddr[9:2];
   wire wr_mapped = ftpg_mapped(wr_idx);
   wire rd_mapped = ftpg_mapped(rd_idx);

   // Stored registers padded to a bus word
   wire [31:0] sync_dir_word = {31'h00000000, sync_dir};
   wire [31:0] shut_ctrl_word = {30'h00000000, shut_ctrl};
   wire [31:0] first_word = {6'h00, first_toggle};
   wire [31:0] second_word = {6'h00, second_toggle};
   wire [31:0] trig_word = {28'h0000000, trig_ctrl};

   // Write data merged under the byte strobes
   wire [31:0] merge_sync = ftpg_merge(sync_dir_word, w_data, w_strb);
   wire [31:0] merge_shut = ftpg_merge(shut_ctrl_word, w_data, w_strb);
   wire [31:0] merge_first = ftpg_merge(first_word, w_data, w_strb);
   wire [31:0] merge_second = ftpg_merge(second_word, w_data, w_strb);
   wire [31:0] merge_trig = ftpg_merge(trig_word, w_data, w_strb);

   ////////////////////////////////////////////////////////////////////////////
   // Pulse placement

   wire start_level = shut_ctrl[ftpg_pkg::START_LEVEL_BIT];
   wire trig_en = trig_ctrl[ftpg_pkg::TRIG_EN_BIT];
   wire [2:0] field_sel = trig_ctrl[ftpg_pkg::FIELD_SEL_LSB +: ftpg_pkg::FIELD_W];
   // Only the mode field count places the pulse
   wire in_field = trig_en && timing.field == field_sel;
   wire hit_first = in_field && ftpg_at(ftpg_pkg::ftpg_toggle_t'(first_toggle), timing);
   wire hit_second = in_field && ftpg_at(ftpg_pkg::ftpg_toggle_t'(second_toggle), timing);
   // Second toggle wins where both positions coincide
   wire next_active = !in_field ? 1'b0 : hit_second ? 1'b0 : hit_first ? 1'b1 : pulse_active;

   ////////////////////////////////////////////////////////////////////////////
   // Read data

   // Live status: pin level, pulse state, field count, chosen-field flag
   wire [31:0] status_word = {26'h0000000, in_field, timing.field, pulse_active, sync_out};

   // Read data selection
   wire [31:0] rd_word = (rd_idx == ftpg_pkg::IDX_SYNC_DIR) ? sync_dir_word :
                         (rd_idx == ftpg_pkg::IDX_SHUT_CTRL) ? shut_ctrl_word :
                         (rd_idx == ftpg_pkg::IDX_FIRST_TOGGLE) ? first_word :
                         (rd_idx == ftpg_pkg::IDX_SECOND_TOGGLE) ? second_word :
                         (rd_idx == ftpg_pkg::IDX_TRIG_CTRL) ? trig_word :
                         (rd_idx == ftpg_pkg::IDX_STATUS) ? status_word : 32'h00000000;

   ////////////////////////////////////////////////////////////////////////////
   // Write channel: address and data taken in either order, response after both

   // Address side; ready again once the response is accepted
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         aw_addr <= 10'h000;
      end else if (aw_take) begin
         s_axi_awready <= 1'b0;
         aw_addr <= s_axi_awaddr;
      end else if (b_take) begin
         s_axi_awready <= 1'b1;
      end
   end

   // Data side; strobes kept for the merge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_wready <= 1'b1;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
      end else if (w_take) begin
         s_axi_wready <= 1'b0;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (b_take) begin
         s_axi_wready <= 1'b1;
      end
   end

   // Response raised one edge after both halves are held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= ftpg_pkg::RESP_OKAY;
      end else if (commit) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_mapped ? ftpg_pkg::RESP_OKAY : ftpg_pkg::RESP_SLVERR;
      end else if (b_take) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Register file update on commit
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync_dir <= ftpg_pkg::RST_SYNC_DIR;
         shut_ctrl <= ftpg_pkg::RST_SHUT_CTRL;
         first_toggle <= ftpg_pkg::RST_TOGGLE;
         second_toggle <= ftpg_pkg::RST_TOGGLE;
         trig_ctrl <= ftpg_pkg::RST_TRIG_CTRL;
      end else if (commit) begin
         if (wr_idx == ftpg_pkg::IDX_SYNC_DIR) sync_dir <= merge_sync[ftpg_pkg::SYNC_DIR_BIT];
         if (wr_idx == ftpg_pkg::IDX_SHUT_CTRL) shut_ctrl <= merge_shut[1:0];
         if (wr_idx == ftpg_pkg::IDX_FIRST_TOGGLE) first_toggle <= merge_first[25:0];
         if (wr_idx == ftpg_pkg::IDX_SECOND_TOGGLE) second_toggle <= merge_second[25:0];
         if (wr_idx == ftpg_pkg::IDX_TRIG_CTRL) trig_ctrl <= merge_trig[3:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read channel: one-cycle answer

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= ftpg_pkg::RESP_OKAY;
      end else if (ar_take) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_mapped ? ftpg_pkg::RESP_OKAY : ftpg_pkg::RESP_SLVERR;
      end else if (r_take) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pulse state and sync pin

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pulse_active <= 1'b0;
         sync_out <= 1'b0;
         sync_oe_n <= 1'b0;
         ext_sync <= 1'b0;
      end else begin
         pulse_active <= next_active;
         sync_out <= start_level ^ next_active;
         sync_oe_n <= sync_dir;
         ext_sync <= sync_dir ? sync_in : 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_write_both;
      !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   endsequence
   sequence s_resp_wait;
      s_axi_bvalid && !s_axi_bready;
   endsequence
   sequence s_aw_first;
      aw_take && !w_take;
   endsequence
   sequence s_read_wait;
      s_axi_rvalid && !s_axi_rready;
   endsequence
   sequence s_enter_pulse;
      hit_first && !hit_second;
   endsequence
   sequence s_pulse_body;
      in_field && !hit_second;
   endsequence

   a_write_resp_follows: assert property (s_write_both |=> s_axi_bvalid) else $error("write response missing");
   a_write_resp_holds: assert property (s_resp_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_read_answer_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer late");
   a_first_toggle_sets: assert property (hit_first && !hit_second |=> pulse_active)
      else $error("first toggle missed");
   a_second_toggle_clears: assert property (hit_second |=> !pulse_active)
      else $error("second toggle missed");
   a_rest_level_out: assert property (!in_field |=> sync_out == $past(start_level))
      else $error("output not at start level");
   a_disabled_no_pulse: assert property (!trig_en |=> !pulse_active)
      else $error("pulse while disabled");
   a_field_select_match: assert property ($rose(pulse_active) |-> $past(timing.field) == $past(field_sel))
      else $error("pulse in wrong field");
   a_hold_between_toggles: assert property (in_field && !hit_first && !hit_second |=> $stable(pulse_active))
      else $error("pulse moved off toggle");
   a_start_level_xor: assert property (sync_out == ($past(start_level) ^ pulse_active))
      else $error("output polarity wrong");
   a_pin_direction: assert property (sync_dir ##1 1 |-> sync_oe_n)
      else $error("pin driven while input");
   a_ext_sync_pass: assert property (sync_dir |=> ext_sync == $past(sync_in))
      else $error("sync input not passed");

   // Write channel ordering
   a_aw_ready_drops: assert property (aw_take |=> !s_axi_awready)
      else $error("address ready stayed high");
   a_w_ready_drops: assert property (w_take |=> !s_axi_wready)
      else $error("data ready stayed high");
   a_resp_needs_both: assert property ($rose(s_axi_bvalid) |-> $past(!s_axi_awready && !s_axi_wready))
      else $error("response before both halves");
   a_ready_after_resp: assert property (b_take |=> s_axi_awready && s_axi_wready && !s_axi_bvalid)
      else $error("write channel not reopened");
   a_addr_first_waits: assert property (s_aw_first |=> !s_axi_bvalid)
      else $error("response before data");

   // Read channel ordering
   a_read_resp_holds: assert property (s_read_wait |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read answer dropped early");
   a_read_reopens: assert property (r_take |=> s_axi_arready && !s_axi_rvalid)
      else $error("read channel not reopened");
   a_status_field_read: assert property (ar_take && rd_idx == ftpg_pkg::IDX_STATUS |=>
      s_axi_rdata[4:2] == $past(timing.field)) else $error("status field count wrong");

   // Register writes land where the map says
   a_sync_dir_lands: assert property (commit && wr_idx == ftpg_pkg::IDX_SYNC_DIR && w_strb[0] |=>
      sync_dir == $past(w_data[ftpg_pkg::SYNC_DIR_BIT])) else $error("sync direction write lost");
   a_start_level_lands: assert property (commit && wr_idx == ftpg_pkg::IDX_SHUT_CTRL && w_strb[0] |=>
      start_level == $past(w_data[ftpg_pkg::START_LEVEL_BIT])) else $error("start level write lost");
   a_first_pos_lands: assert property (commit && wr_idx == ftpg_pkg::IDX_FIRST_TOGGLE && (&w_strb) |=>
      first_toggle == $past(w_data[25:0])) else $error("first toggle write lost");
   a_second_pos_lands: assert property (commit && wr_idx == ftpg_pkg::IDX_SECOND_TOGGLE && (&w_strb) |=>
      second_toggle == $past(w_data[25:0])) else $error("second toggle write lost");
   a_trig_ctrl_lands: assert property (commit && wr_idx == ftpg_pkg::IDX_TRIG_CTRL && w_strb[0] |=>
      trig_ctrl == $past(w_data[3:0])) else $error("trigger control write lost");
   a_unmapped_ignored: assert property (commit && !wr_mapped |=> $stable(trig_ctrl) && $stable(first_toggle) &&
      $stable(second_toggle) && $stable(shut_ctrl) && $stable(sync_dir)) else $error("unmapped write landed");

   // Pulse shape inside and outside the chosen field
   a_pulse_body_holds: assert property (s_enter_pulse ##1 s_pulse_body |=> pulse_active)
      else $error("pulse ended between toggles");
   a_leave_field_ends: assert property (pulse_active && !in_field |=> !pulse_active)
      else $error("pulse kept outside field");
   a_pulse_needs_enable: assert property (pulse_active |-> $past(trig_en))
      else $error("pulse without enable");
   a_rise_on_first: assert property ($rose(pulse_active) |-> $past(hit_first))
      else $error("pulse rose off first toggle");
   a_fall_on_second: assert property ($fell(pulse_active) |-> $past(hit_second) || $past(!in_field))
      else $error("pulse fell off second toggle");

   // Sync pin direction
   a_driven_as_output: assert property (!sync_dir |=> !sync_oe_n)
      else $error("pin released while output");
   a_ext_sync_idle: assert property (!sync_dir |=> !ext_sync)
      else $error("sync input passed while output");

endmodule : ftpg_field_trigger

// ---- test/ftpg_sync_partner.sv ----
// Camera-side model of the sync pin and its external sync source
`timescale 1ns/1ns
module ftpg_sync_partner (
   input wire logic sync_out,
   input wire logic sync_oe_n,
   input wire logic ext_level,
   output logic pin,
   output logic sync_in
);
   // Pin level from whichever side drives it
   assign pin = sync_oe_n ? ext_level : sync_out;
   assign sync_in = pin;
endmodule : ftpg_sync_partner

// ---- test/tb_top.sv ----
// Self-checking bench for the field trigger pulse generator
`timescale 1ns/1ns
module tb_top;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, en, lvl, act;
   logic sync_in, sync_out, sync_oe_n, ext_sync, ext_level, pin;
   logic [9:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp;
   logic [2:0] sel;
   logic [11:0] on_ln, off_ln;
   logic [12:0] on_px, off_px;
   ftpg_pkg::ftpg_timing_t timing;
   int error_cnt = 0;
   int compares = 0;
   ////////////////////////////////////////////////////////////////////////////
   // Design and far-side model
   ftpg_field_trigger dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .timing(timing), .sync_in(sync_in), .sync_out(sync_out),
      .sync_oe_n(sync_oe_n), .ext_sync(ext_sync));
   ftpg_sync_partner partner (.sync_out(sync_out), .sync_oe_n(sync_oe_n), .ext_level(ext_level),
      .pin(pin), .sync_in(sync_in));
   ////////////////////////////////////////////////////////////////////////////
   // Compare, bus and raster tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // One write or read; for a read d is the expected data
   task automatic axi(input logic wr, input logic [7:0] i, input logic [31:0] d, input logic [1:0] er);
      int n;
      logic b;
      logic [1:0] r;
      logic [31:0] got;
      n = 0;
      b = 1'h0;
      r = 2'h0;
      got = 32'h0;
      @(posedge aclk);
      if (wr) begin
         awaddr <= {i, 2'h0};
         wdata <= d;
         awvalid <= 1'h1;
         wvalid <= 1'h1;
         bready <= 1'h1;
      end else begin
         araddr <= {i, 2'h0};
         arvalid <= 1'h1;
         rready <= 1'h1;
      end
      // Each channel released at the edge that takes it; answer taken at its own edge
      while (!b && n < 60) begin
         @(posedge aclk);
         n++;
         b = wr ? bvalid : rvalid;
         r = wr ? bresp : rresp;
         got = rdata;
         if (awvalid && awready) awvalid <= 1'h0;
         if (wvalid && wready) wvalid <= 1'h0;
         if (arvalid && arready) arvalid <= 1'h0;
         if (b && wr) bready <= 1'h0;
         if (b && !wr) rready <= 1'h0;
      end
      chk({31'h0, b}, 32'h1);
      chk({30'h0, r}, {30'h0, er});
      if (!wr) chk(got, d);
   endtask : axi
   task automatic cfg(input logic l, input logic e, input logic [2:0] s, input logic [11:0] a,
                      input logic [12:0] b, input logic [11:0] c, input logic [12:0] d);
      lvl = l;
      en = e;
      sel = s;
      on_ln = a;
      on_px = b;
      off_ln = c;
      off_px = d;
      act = 1'h0;
      axi(1'h1, ftpg_pkg::IDX_SHUT_CTRL, {30'h0, l, 1'h0}, ftpg_pkg::RESP_OKAY);
      axi(1'h1, ftpg_pkg::IDX_FIRST_TOGGLE, {6'h0, b, 1'h0, a}, ftpg_pkg::RESP_OKAY);
      axi(1'h1, ftpg_pkg::IDX_SECOND_TOGGLE, {6'h0, d, 1'h0, c}, ftpg_pkg::RESP_OKAY);
      axi(1'h1, ftpg_pkg::IDX_TRIG_CTRL, {28'h0, e, s}, ftpg_pkg::RESP_OKAY);
      axi(1'h0, ftpg_pkg::IDX_FIRST_TOGGLE, {6'h0, b, 1'h0, a}, ftpg_pkg::RESP_OKAY);
   endtask : cfg
   // Walks pixels 0..n of one line, checking the pin after each position
   task automatic walk(input logic [2:0] f, input logic [11:0] l, input int n);
      for (int p = 0; p <= n; p++) begin
         @(posedge aclk);
         timing <= '{field: f, line: l, pixel: 13'(p)};
         if (!(en && f == sel)) act = 1'h0;
         else if (l == off_ln && p == off_px) act = 1'h0;
         else if (l == on_ln && p == on_px) act = 1'h1;
         @(posedge aclk);
         #1;
         chk({31'h0, sync_out}, {31'h0, lvl ^ act});
      end
   endtask : walk
   ////////////////////////////////////////////////////////////////////////////
   // Scenarios
   // Reset state, defaults and unmapped places
   task automatic t_defaults;
      chk({31'h0, sync_oe_n}, 32'h0);
      axi(1'h0, ftpg_pkg::IDX_SYNC_DIR, 32'h0, ftpg_pkg::RESP_OKAY);
      axi(1'h0, ftpg_pkg::IDX_TRIG_CTRL, 32'h0, ftpg_pkg::RESP_OKAY);
      axi(1'h0, 8'h00, 32'h0, ftpg_pkg::RESP_SLVERR);
      axi(1'h1, 8'h13, 32'h1, ftpg_pkg::RESP_SLVERR);
   endtask : t_defaults
   // Pulse in the chosen field only, and only on the chosen line
   task automatic t_one_line;
      cfg(1'h1, 1'h1, 3'h3, 12'h2, 13'h5, 12'h2, 13'h9);
      walk(3'h3, 12'h2, 12);
      walk(3'h2, 12'h2, 12);
      walk(3'h3, 12'h7, 12);
   endtask : t_one_line
   // Pulse spanning lines, low start level
   task automatic t_multi_line;
      cfg(1'h0, 1'h1, 3'h5, 12'h4, 13'h3, 12'h6, 13'h1);
      for (int k = 4; k < 7; k++) walk(3'h5, 12'(k), 6);
   endtask : t_multi_line
   // Disabled pulse and coincident toggles both rest at start level
   task automatic t_no_pulse;
      cfg(1'h1, 1'h0, 3'h3, 12'h2, 13'h5, 12'h2, 13'h9);
      walk(3'h3, 12'h2, 12);
      cfg(1'h1, 1'h1, 3'h3, 12'h2, 13'h5, 12'h2, 13'h5);
      walk(3'h3, 12'h2, 12);
   endtask : t_no_pulse
   // Every field count code
   task automatic t_all_fields;
      for (int s = 0; s < 8; s++) begin
         cfg(1'h0, 1'h1, 3'(s), 12'h0, 13'h2, 12'h0, 13'h4);
         walk(3'(s), 12'h0, 5);
      end
   endtask : t_all_fields
   // Status word in field 7, enabled, pulse over; a write to it is ignored
   task automatic t_status;
      axi(1'h1, ftpg_pkg::IDX_STATUS, 32'hFFFFFFFF, ftpg_pkg::RESP_OKAY);
      axi(1'h0, ftpg_pkg::IDX_STATUS, 32'h0000003C, ftpg_pkg::RESP_OKAY);
   endtask : t_status
   // Sync pin turned to an input and back
   task automatic t_sync_pin;
      axi(1'h1, ftpg_pkg::IDX_SYNC_DIR, 32'h1, ftpg_pkg::RESP_OKAY);
      ext_level <= 1'h1;
      repeat (2) @(posedge aclk);
      #1;
      chk({30'h0, sync_oe_n, ext_sync}, 32'h3);
      axi(1'h0, ftpg_pkg::IDX_SYNC_DIR, 32'h1, ftpg_pkg::RESP_OKAY);
      axi(1'h1, ftpg_pkg::IDX_SYNC_DIR, 32'h0, ftpg_pkg::RESP_OKAY);
      repeat (2) @(posedge aclk);
      #1;
      chk({29'h0, sync_oe_n, ext_sync, pin}, {31'h0, lvl ^ act});
   endtask : t_sync_pin
   task print_verdict;
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : print_verdict
   ////////////////////////////////////////////////////////////////////////////
   // Clock, watchdog and main sequence
   initial begin
      aclk = 1'h0;
      forever #2 aclk = ~aclk;
   end
   initial begin
      #100000;
      error_cnt++;
      print_verdict;
   end
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, ext_level} = 7'h0;
      {awaddr, araddr, wdata, timing} = '0;
      {en, lvl, act, sel} = 6'h0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'h1;
      t_defaults;
      t_one_line;
      t_multi_line;
      t_no_pulse;
      t_all_fields;
      t_status;
      t_sync_pin;
      print_verdict;
   end
endmodule : tb_top
